/* File: iomb_pkg.sv */
// package: constants, types and states for the mailbox
package iomb_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam logic [10:0] PROC_ADDR_HOLDER = 11'h001;
    localparam logic [10:0] PROC_DATA_HOLDER = 11'h002;
    localparam logic [10:0] PROC_FLAGS = 11'h003;
    localparam logic [10:0] HOST_ADDR_HOLDER = 11'h400;
    localparam logic [10:0] HOST_DATA_HOLDER = 11'h401;
    localparam logic [10:0] HOST_FLAGS = 11'h402;
    localparam int BIT_HOST_PEND = 7;
    localparam int BIT_PROC_PEND = 6;
    localparam int BIT_DATA_WR = 1;
    localparam int BIT_ADDR_WR = 0;
    localparam logic [7:0] HOLDER_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam int CLOCK_HZ = 200000000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PROC_ADDR = 3'b001,
        ST_PROC_READ = 3'b011,
        ST_PROC_WRITE = 3'b010,
        ST_HOST_ADDR = 3'b100,
        ST_HOST_READ = 3'b101,
        ST_HOST_WRITE = 3'b110
    } iomb_state_t;

    typedef enum logic [1:0] {
        SEL_NONE = 2'h0,
        SEL_ADDR = 2'h1,
        SEL_DATA = 2'h2,
        SEL_FLAGS = 2'h3
    } iomb_sel_t;

    typedef struct packed {
        logic host_pend;
        logic proc_pend;
        logic data_wr;
        logic addr_wr;
    } iomb_flags_t;
endpackage

/* File: iomb_sync.sv */
// module: two-flop synchroniser for host strobes
`timescale 1ns/1ps
`default_nettype none
module iomb_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_d,
    output logic o_q
);
    logic stage1;
    logic next_stage1;
    logic next_q;

    always_comb begin
        next_stage1 = i_nrst ? i_d : RESET_VAL;
        next_q = i_nrst ? stage1 : RESET_VAL;
    end

    always_ff @(posedge i_clk) begin
        stage1 <= next_stage1;
        o_q <= next_q;
    end
endmodule
`default_nettype wire

/* File: iomb_mailbox.sv */
// module: shared mailbox between signal processor and card host
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - decode 001h-003h processor, 400h-402h host
// - shared 8-bit address holder, both directions
// - shared 8-bit data holder, both sides
// - flags read-only, bits 5:2 read zero
// - processor holder write sets host-pending bit 7
// - host interrupt low when pending and enabled
// - interrupt-pending status mirrors host-pending flag
// - host holder read or reset clears host-pending
// - host holder write sets processor-pending bit 6
// - processor holder read or reset clears processor-pending
// - data-written bit set on write, cleared on read
// - address-written bit set on write, cleared on read
// - seven-state arbitration machine with idle
// - reset enters idle; idle awaits access
// - synchronise host read, write strobes
// - processor select moves to processor address
// - matching address then read or write
// - processor read drives bus, write captures
// - synced host strobe in idle enters host address
// - host match then read or write state
// - host read returns after strobe released
// - host write returns after strobe released
// - interrupt-pending read-only, clears, resets zero
module iomb_mailbox (
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_PROC_SEL_N,
    input wire logic I_PROC_RD_N,
    input wire logic I_PROC_WR_N,
    input wire logic [10:0] I_PROC_ADDR,
    input wire logic [7:0] I_PROC_WDATA,
    output logic [7:0] O_PROC_RDATA,
    output logic O_PROC_RDATA_OE_N,
    input wire logic I_HOST_RD_N,
    input wire logic I_HOST_WR_N,
    input wire logic [10:0] I_HOST_ADDR,
    input wire logic I_HOST_IO_SEL,
    input wire logic [7:0] I_HOST_WDATA,
    output logic [7:0] O_HOST_RDATA,
    output logic O_HOST_RDATA_OE_N,
    input wire logic I_IRQ_ENABLE,
    output logic O_HOST_IRQ_N,
    output logic O_INT_PENDING,
    output logic [2:0] O_STATE
);
    iomb_pkg::iomb_state_t state;
    iomb_pkg::iomb_state_t next_state;
    iomb_pkg::iomb_sel_t sel;
    iomb_pkg::iomb_sel_t next_sel;
    iomb_pkg::iomb_flags_t flags;
    iomb_pkg::iomb_flags_t next_flags;
    logic [7:0] addr_holder;
    logic [7:0] next_addr_holder;
    logic [7:0] data_holder;
    logic [7:0] next_data_holder;
    logic [7:0] next_proc_rdata;
    logic [7:0] next_host_rdata;
    logic next_proc_oe_n;
    logic next_host_oe_n;
    logic next_irq_n;
    logic next_int_pending;
    logic host_rd_n_sync;
    logic host_wr_n_sync;
    logic proc_match;
    logic host_match;
    logic [7:0] flags_word;
    logic [7:0] sel_word;
    iomb_pkg::iomb_sel_t proc_dec;
    iomb_pkg::iomb_sel_t host_dec;

    iomb_sync #(.RESET_VAL(1'b1)) u_sync_rd (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_d(I_HOST_RD_N),
        .o_q(host_rd_n_sync)
    );
    iomb_sync #(.RESET_VAL(1'b1)) u_sync_wr (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_d(I_HOST_WR_N),
        .o_q(host_wr_n_sync)
    );

    // two address maps, one register set
    always_comb begin
        case (I_PROC_ADDR)
            iomb_pkg::PROC_ADDR_HOLDER: proc_dec = iomb_pkg::SEL_ADDR;
            iomb_pkg::PROC_DATA_HOLDER: proc_dec = iomb_pkg::SEL_DATA;
            iomb_pkg::PROC_FLAGS: proc_dec = iomb_pkg::SEL_FLAGS;
            default: proc_dec = iomb_pkg::SEL_NONE;
        endcase
        case (I_HOST_ADDR)
            iomb_pkg::HOST_ADDR_HOLDER: host_dec = iomb_pkg::SEL_ADDR;
            iomb_pkg::HOST_DATA_HOLDER: host_dec = iomb_pkg::SEL_DATA;
            iomb_pkg::HOST_FLAGS: host_dec = iomb_pkg::SEL_FLAGS;
            default: host_dec = iomb_pkg::SEL_NONE;
        endcase
        proc_match = (proc_dec != iomb_pkg::SEL_NONE);
        host_match = I_HOST_IO_SEL && (host_dec != iomb_pkg::SEL_NONE);
    end

    always_comb begin
        flags_word = 8'h00;
        flags_word[iomb_pkg::BIT_HOST_PEND] = flags.host_pend;
        flags_word[iomb_pkg::BIT_PROC_PEND] = flags.proc_pend;
        flags_word[iomb_pkg::BIT_DATA_WR] = flags.data_wr;
        flags_word[iomb_pkg::BIT_ADDR_WR] = flags.addr_wr;
        case (next_sel)
            iomb_pkg::SEL_ADDR: sel_word = addr_holder;
            iomb_pkg::SEL_DATA: sel_word = data_holder;
            iomb_pkg::SEL_FLAGS: sel_word = flags_word;
            default: sel_word = 8'h00;
        endcase
    end

    always_comb begin
        next_state = state;
        next_sel = sel;
        case (state)
            iomb_pkg::ST_IDLE: begin
                next_sel = iomb_pkg::SEL_NONE;
                if (!I_PROC_SEL_N) begin
                    next_state = iomb_pkg::ST_PROC_ADDR;
                end else if (!host_rd_n_sync || !host_wr_n_sync) begin
                    next_state = iomb_pkg::ST_HOST_ADDR;
                end
            end
            iomb_pkg::ST_PROC_ADDR: begin
                if (I_PROC_SEL_N) begin
                    next_state = iomb_pkg::ST_IDLE;
                end else if (proc_match && !I_PROC_RD_N) begin
                    next_state = iomb_pkg::ST_PROC_READ;
                    next_sel = proc_dec;
                end else if (proc_match && !I_PROC_WR_N) begin
                    next_state = iomb_pkg::ST_PROC_WRITE;
                    next_sel = proc_dec;
                end
            end
            iomb_pkg::ST_HOST_ADDR: begin
                if (host_rd_n_sync && host_wr_n_sync) begin
                    next_state = iomb_pkg::ST_IDLE;
                end else if (host_match && !host_rd_n_sync) begin
                    next_state = iomb_pkg::ST_HOST_READ;
                    next_sel = host_dec;
                end else if (host_match && !host_wr_n_sync) begin
                    next_state = iomb_pkg::ST_HOST_WRITE;
                    next_sel = host_dec;
                end
            end
            iomb_pkg::ST_PROC_READ: next_state = iomb_pkg::ST_IDLE;
            iomb_pkg::ST_PROC_WRITE: next_state = iomb_pkg::ST_IDLE;
            iomb_pkg::ST_HOST_READ: begin
                if (host_rd_n_sync) begin
                    next_state = iomb_pkg::ST_IDLE;
                end
            end
            iomb_pkg::ST_HOST_WRITE: begin
                if (host_wr_n_sync) begin
                    next_state = iomb_pkg::ST_IDLE;
                end
            end
            default: next_state = iomb_pkg::ST_IDLE;
        endcase
        if (!I_NRST) begin
            next_state = iomb_pkg::ST_IDLE;
            next_sel = iomb_pkg::SEL_NONE;
        end
    end

    // holders and flags
    always_comb begin
        logic proc_wr;
        logic host_wr;
        logic proc_rd;
        logic host_rd;
        logic host_first;
        proc_wr = (state == iomb_pkg::ST_PROC_WRITE);
        proc_rd = (state == iomb_pkg::ST_PROC_READ);
        host_first = (state == iomb_pkg::ST_HOST_ADDR);
        host_wr = host_first && (next_state == iomb_pkg::ST_HOST_WRITE);
        host_rd = host_first && (next_state == iomb_pkg::ST_HOST_READ);
        next_addr_holder = addr_holder;
        next_data_holder = data_holder;
        next_flags = flags;
        if (host_rd && (host_dec == iomb_pkg::SEL_ADDR || host_dec == iomb_pkg::SEL_DATA)) begin
            next_flags.host_pend = 1'b0;
        end
        if (proc_rd && (sel == iomb_pkg::SEL_ADDR || sel == iomb_pkg::SEL_DATA)) begin
            next_flags.proc_pend = 1'b0;
        end
        if ((proc_rd && sel == iomb_pkg::SEL_DATA) || (host_rd && host_dec == iomb_pkg::SEL_DATA)) begin
            next_flags.data_wr = 1'b0;
        end
        if ((proc_rd && sel == iomb_pkg::SEL_ADDR) || (host_rd && host_dec == iomb_pkg::SEL_ADDR)) begin
            next_flags.addr_wr = 1'b0;
        end
        // address holder writes from either side
        if (proc_wr && sel == iomb_pkg::SEL_ADDR) begin
            next_addr_holder = I_PROC_WDATA;
        end else if (host_wr && host_dec == iomb_pkg::SEL_ADDR) begin
            next_addr_holder = I_HOST_WDATA;
        end
        // data holder writes from either side
        if (proc_wr && sel == iomb_pkg::SEL_DATA) begin
            next_data_holder = I_PROC_WDATA;
        end else if (host_wr && host_dec == iomb_pkg::SEL_DATA) begin
            next_data_holder = I_HOST_WDATA;
        end
        if (proc_wr && (sel == iomb_pkg::SEL_ADDR || sel == iomb_pkg::SEL_DATA)) begin
            next_flags.host_pend = 1'b1;
        end
        if (host_wr && (host_dec == iomb_pkg::SEL_ADDR || host_dec == iomb_pkg::SEL_DATA)) begin
            next_flags.proc_pend = 1'b1;
        end
        if ((proc_wr && sel == iomb_pkg::SEL_DATA) || (host_wr && host_dec == iomb_pkg::SEL_DATA)) begin
            next_flags.data_wr = 1'b1;
        end
        if ((proc_wr && sel == iomb_pkg::SEL_ADDR) || (host_wr && host_dec == iomb_pkg::SEL_ADDR)) begin
            next_flags.addr_wr = 1'b1;
        end
        if (!I_NRST) begin
            next_addr_holder = iomb_pkg::HOLDER_RESET;
            next_data_holder = iomb_pkg::HOLDER_RESET;
            next_flags = iomb_pkg::iomb_flags_t'(iomb_pkg::FLAGS_RESET[3:0]);
        end
    end

    // output registers
    always_comb begin
        next_proc_rdata = O_PROC_RDATA;
        next_host_rdata = O_HOST_RDATA;
        next_proc_oe_n = !(next_state == iomb_pkg::ST_PROC_READ);
        next_host_oe_n = !(next_state == iomb_pkg::ST_HOST_READ);
        if (next_state == iomb_pkg::ST_PROC_READ) begin
            next_proc_rdata = sel_word;
        end
        if (next_state == iomb_pkg::ST_HOST_READ) begin
            next_host_rdata = sel_word;
        end
        next_irq_n = !(next_flags.host_pend && I_IRQ_ENABLE);
        // clears with the flag, resets zero
        next_int_pending = next_flags.host_pend;
        if (!I_NRST) begin
            next_proc_rdata = 8'h00;
            next_host_rdata = 8'h00;
            next_proc_oe_n = 1'b1;
            next_host_oe_n = 1'b1;
            next_irq_n = 1'b1;
            next_int_pending = 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        state <= next_state;
        sel <= next_sel;
        flags <= next_flags;
        addr_holder <= next_addr_holder;
        data_holder <= next_data_holder;
        O_PROC_RDATA <= next_proc_rdata;
        O_HOST_RDATA <= next_host_rdata;
        O_PROC_RDATA_OE_N <= next_proc_oe_n;
        O_HOST_RDATA_OE_N <= next_host_oe_n;
        O_HOST_IRQ_N <= next_irq_n;
        O_INT_PENDING <= next_int_pending;
        O_STATE <= next_state;
    end

    a_reset_idle: assert property (@(posedge I_CLK) !I_NRST |=> state == iomb_pkg::ST_IDLE)
        else $error("not idle after reset");
    a_irq_follows: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        O_HOST_IRQ_N == !(flags.host_pend && $past(I_IRQ_ENABLE)))
        else $error("host interrupt mismatch");
    a_int_mirror: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        O_INT_PENDING == flags.host_pend)
        else $error("pending status mismatch");
    a_proc_set: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        state == iomb_pkg::ST_PROC_WRITE && sel == iomb_pkg::SEL_DATA
        |=> flags.host_pend && flags.data_wr && data_holder == $past(I_PROC_WDATA))
        else $error("processor write effect missing");
    a_host_set: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        $rose(state == iomb_pkg::ST_HOST_WRITE) && sel == iomb_pkg::SEL_ADDR
        |-> flags.proc_pend && flags.addr_wr)
        else $error("host write effect missing");
    a_host_clear: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        $rose(state == iomb_pkg::ST_HOST_READ) && sel == iomb_pkg::SEL_DATA
        |-> !flags.host_pend && !flags.data_wr)
        else $error("host read did not clear");
    a_proc_clear: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        state == iomb_pkg::ST_PROC_READ && sel == iomb_pkg::SEL_ADDR
        |=> !flags.proc_pend && !flags.addr_wr)
        else $error("processor read did not clear");
    a_proc_first: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        state == iomb_pkg::ST_IDLE && !I_PROC_SEL_N |=> state == iomb_pkg::ST_PROC_ADDR)
        else $error("processor not granted");
    a_host_hold: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        state == iomb_pkg::ST_HOST_READ && !host_rd_n_sync |=> state == iomb_pkg::ST_HOST_READ)
        else $error("host read left early");
    a_reserved_zero: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        state == iomb_pkg::ST_PROC_READ && sel == iomb_pkg::SEL_FLAGS |-> O_PROC_RDATA[5:2] == 4'h0)
        else $error("reserved bits nonzero");
    c_proc_write: cover property (@(posedge I_CLK) state == iomb_pkg::ST_PROC_WRITE);
    c_host_read: cover property (@(posedge I_CLK) state == iomb_pkg::ST_HOST_READ);
    c_host_write: cover property (@(posedge I_CLK) state == iomb_pkg::ST_HOST_WRITE);
    c_irq: cover property (@(posedge I_CLK) !O_HOST_IRQ_N);
endmodule
`default_nettype wire

/* File: iomb_partner.sv */
// far-side model of the processor and host bus adapter
`timescale 1ns/1ps
`default_nettype none
module iomb_partner (
    input wire logic i_clk,
    input wire logic [2:0] i_state,
    input wire logic [7:0] i_prdata,
    input wire logic [7:0] i_hrdata,
    output logic [2:0] o_pctl,
    output logic [10:0] o_paddr,
    output logic [7:0] o_pwdata,
    output logic [2:0] o_hctl,
    output logic [10:0] o_haddr,
    output logic [7:0] o_hwdata
);
    int timeouts = 0;
    initial begin
        o_pctl = 3'h7;
        o_paddr = 11'h000;
        o_pwdata = 8'h00;
        o_hctl = 3'h3;
        o_haddr = 11'h000;
        o_hwdata = 8'h00;
    end
    task automatic wait_st(input logic [2:0] a, input logic [2:0] b);
        int n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (i_state !== a && i_state !== b && n < 60);
        if (n >= 60) timeouts++;
    endtask
    task automatic proc_acc(input logic wr, input logic [10:0] a, input logic [7:0] d,
            output logic [7:0] q);
        @(posedge i_clk);
        o_pctl <= {1'b0, wr, ~wr};
        o_paddr <= a;
        o_pwdata <= d;
        wait_st(iomb_pkg::ST_PROC_READ, iomb_pkg::ST_PROC_WRITE);
        @(posedge i_clk);
        o_pctl <= 3'h7;
        o_paddr <= ~a;
        o_pwdata <= ~d;
        #1;
        q = i_prdata;
    endtask
    task automatic host_acc(input logic wr, input logic [10:0] a, input logic [7:0] d,
            output logic [7:0] q);
        @(posedge i_clk);
        o_hctl <= {1'b1, wr, ~wr};
        o_haddr <= a;
        o_hwdata <= d;
        wait_st(iomb_pkg::ST_HOST_READ, iomb_pkg::ST_HOST_WRITE);
        @(posedge i_clk);
        #1;
        q = i_hrdata;
        @(posedge i_clk);
        o_hctl <= 3'h3;
        o_haddr <= ~a;
        o_hwdata <= ~d;
        wait_st(iomb_pkg::ST_IDLE, iomb_pkg::ST_IDLE);
    endtask
endmodule
`default_nettype wire

/* File: iomb_mailbox_tb.sv */
// self-checking bench for the shared mailbox
`timescale 1ns/1ps
`default_nettype none
module iomb_mailbox_tb;
    logic clk, nrst, irq_en, proe_n, hroe_n, irq_n, int_pend;
    logic [2:0] pctl, hctl, st;
    logic [10:0] paddr, haddr;
    logic [7:0] pwdata, hwdata, prdata, hrdata;
    logic [7:0] p_bus, h_bus;
    int miscompares = 0, cmp_count = 0;
    time t_proc, t_host;
    iomb_mailbox uut (
        .I_CLK(clk),
        .I_NRST(nrst),
        .I_PROC_SEL_N(pctl[2]),
        .I_PROC_RD_N(pctl[1]),
        .I_PROC_WR_N(pctl[0]),
        .I_PROC_ADDR(paddr),
        .I_PROC_WDATA(pwdata),
        .O_PROC_RDATA(prdata),
        .O_PROC_RDATA_OE_N(proe_n),
        .I_HOST_RD_N(hctl[1]),
        .I_HOST_WR_N(hctl[0]),
        .I_HOST_ADDR(haddr),
        .I_HOST_IO_SEL(hctl[2]),
        .I_HOST_WDATA(hwdata),
        .O_HOST_RDATA(hrdata),
        .O_HOST_RDATA_OE_N(hroe_n),
        .I_IRQ_ENABLE(irq_en),
        .O_HOST_IRQ_N(irq_n),
        .O_INT_PENDING(int_pend),
        .O_STATE(st)
    );
    iomb_partner u_p (
        .i_clk(clk),
        .i_state(st),
        .i_prdata(prdata),
        .i_hrdata(hrdata),
        .o_pctl(pctl),
        .o_paddr(paddr),
        .o_pwdata(pwdata),
        .o_hctl(hctl),
        .o_haddr(haddr),
        .o_hwdata(hwdata)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // read data as seen while the device drives each bus
    always @(posedge clk) begin
        p_bus <= proe_n ? 8'hxx : prdata;
        h_bus <= hroe_n ? 8'hxx : hrdata;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp || u_p.timeouts != 0) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
        if (u_p.timeouts != 0) results();
    endtask
    task automatic results();
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic acc(input logic host, input logic w, input logic [10:0] a,
            input logic [7:0] d, input logic [7:0] exp);
        logic [7:0] r;
        if (host) u_p.host_acc(w, a, d, r);
        else u_p.proc_acc(w, a, d, r);
        if (!w) begin
            chk(r, exp);
            chk(host ? h_bus : p_bus, exp);
        end
    endtask
    task automatic stat(input logic [7:0] exp);
        repeat (2) @(posedge clk);
        #1;
        chk({1'b0, st, hroe_n, proe_n, irq_n, int_pend}, exp);
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
    endtask
    initial begin
        irq_en <= 1'b1;
        do_reset();
        stat(8'h0e);
        acc(1'b0, 1'b0, 11'h003, 8'h00, 8'h00);
        acc(1'b1, 1'b0, 11'h400, 8'h00, 8'h00);
        $display("test reset values done");
        acc(1'b0, 1'b1, 11'h001, 8'h5a, 8'h00);
        stat(8'h0d);
        acc(1'b0, 1'b1, 11'h002, 8'hc3, 8'h00);
        acc(1'b0, 1'b1, 11'h003, 8'hff, 8'h00);
        acc(1'b0, 1'b0, 11'h003, 8'h00, 8'h83);
        @(posedge clk);
        irq_en <= 1'b0;
        stat(8'h0f);
        acc(1'b1, 1'b0, 11'h402, 8'h00, 8'h83);
        acc(1'b1, 1'b0, 11'h400, 8'h00, 8'h5a);
        stat(8'h0e);
        acc(1'b1, 1'b0, 11'h402, 8'h00, 8'h02);
        acc(1'b1, 1'b0, 11'h401, 8'h00, 8'hc3);
        $display("test processor to host done");
        acc(1'b1, 1'b1, 11'h400, 8'h3c, 8'h00);
        acc(1'b1, 1'b1, 11'h401, 8'h96, 8'h00);
        acc(1'b0, 1'b0, 11'h003, 8'h00, 8'h43);
        acc(1'b0, 1'b0, 11'h001, 8'h00, 8'h3c);
        acc(1'b0, 1'b0, 11'h003, 8'h00, 8'h02);
        acc(1'b0, 1'b0, 11'h002, 8'h00, 8'h96);
        fork
            begin
                acc(1'b1, 1'b0, 11'h401, 8'h00, 8'h96);
                t_host = $time;
            end
            begin
                repeat (2) @(posedge clk);
                acc(1'b0, 1'b0, 11'h002, 8'h00, 8'h96);
                t_proc = $time;
            end
        join
        chk({7'h00, t_proc < t_host}, 8'h01);
        $display("test host to processor and contention done");
        acc(1'b0, 1'b1, 11'h001, 8'h11, 8'h00);
        stat(8'h0f);
        @(posedge clk);
        do_reset();
        stat(8'h0e);
        acc(1'b0, 1'b0, 11'h003, 8'h00, 8'h00);
        $display("test mid-run reset done");
        results();
    end
endmodule
`default_nettype wire
